// >>> src/hbi_pkg.sv
// Constants shared by both ends of the host processor bus link
package hbi_pkg;
   //---------------------------------------------------------------
   // Device register space
   //---------------------------------------------------------------
   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;
   localparam logic [10:0] ADR_GLOBAL_CONFIG = 11'h000;
   localparam logic [10:0] ADR_IRQ_STATUS = 11'h001;
   localparam logic [10:0] ADR_IRQ_MASK = 11'h002;
   localparam logic [10:0] ADR_SCRATCH_BASE = 11'h010;
   localparam logic [7:0] GLOBAL_CONFIG_RST = 8'h00;
   localparam logic [7:0] IRQ_MASK_RST = 8'hff;
   localparam int IRQ_LEVEL_BIT = 2;
   localparam int IRQ_OPEN_DRAIN_BIT = 3;
   //---------------------------------------------------------------
   // Timing
   //---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int RESET_MAX_NS = 2000;
   localparam int RESET_CYCLES = RESET_MAX_NS / CLK_PERIOD_NS;
   localparam int HOST_PHASE_CYCLES = 8;
   //---------------------------------------------------------------
   // Serial frame: read flag, address, data, first bit first
   //---------------------------------------------------------------
   localparam int SER_HDR_BITS = 12;
   localparam int SER_FRAME_BITS = 20;
   //---------------------------------------------------------------
   // Host controller APB map
   //---------------------------------------------------------------
   localparam logic [11:0] APB_CMD = 12'h000;
   localparam logic [11:0] APB_WDATA = 12'h004;
   localparam logic [11:0] APB_STATUS = 12'h008;
   localparam logic [11:0] APB_MODE = 12'h00c;
   localparam int CMD_WRITE_BIT = 16;
   localparam int CMD_START_BIT = 31;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_IRQ_BIT = 2;
   localparam int ST_RDATA_LSB = 8;
   localparam int MODE_PAR_BIT = 0;
   localparam int MODE_FAM_BIT = 1;
   localparam int MODE_MUX_BIT = 2;
   localparam int MODE_RST_BIT = 3;
   localparam logic [3:0] MODE_RST = 4'h1;
endpackage

// >>> src/hbi_if.sv
// Pin bundle between the host controller and the device port
`timescale 1ns/1ps
`default_nettype none
interface hbi_if;
   logic rst_pin_n;
   logic par_sel;
   logic bus_family_select;
   logic bus_multiplex_select;
   logic cs_n;
   logic strb_pin;
   logic dirwr_pin;
   logic addr_capture_strobe;
   logic [10:0] addr;
   logic [7:0] d_host;
   logic d_host_oe;
   logic [7:0] d_dev;
   logic d_dev_oe;
   logic resp_pin;
   logic irq_pin;
   logic irq_oe;
   logic [7:0] d_bus;
   logic irq_line;

   // Pull-ups on the shared data bus and the request line
   assign d_bus = d_dev_oe ? d_dev : (d_host_oe ? d_host : 8'hff);
   assign irq_line = irq_oe ? irq_pin : 1'b1;

   modport dev(input rst_pin_n, input par_sel, input bus_family_select,
      input bus_multiplex_select, input cs_n, input strb_pin, input dirwr_pin,
      input addr_capture_strobe, input addr, input d_bus, output d_dev,
      output d_dev_oe, output resp_pin, output irq_pin, output irq_oe);
   modport host(output rst_pin_n, output par_sel, output bus_family_select,
      output bus_multiplex_select, output cs_n, output strb_pin, output dirwr_pin,
      output addr_capture_strobe, output addr, output d_host, output d_host_oe,
      input d_bus, input resp_pin, input irq_line);
endinterface
`default_nettype wire

// >>> src/hbi_dev.sv
// Device end of the host processor port with its register space
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: Reset pin low restarts device within 2 us
// R2: Request output asserted while unmasked source pending
// R3: Config bits 3:2 pick request drive, level
// R4: Chip select high means bus is ignored
// R5: Host lowers select per access, holds it
// R6: Type strap low serial, high parallel
// R7: Family strap low data strobe, high separate
// R8: Multiplex strap low plain, high multiplexed
// R9: Separate style latches address on capture fall
// R10: Strobe style latches address on capture fall
// R11: Capture pin high unmultiplexed, low serial
// R12: Serial input bits taken on shift rise
// R13: Serial output bit changes on shift fall
// R14: Strobe style direction picks sample or drive
// R15: Host sets direction low write, high read
// R16: Read strobe low makes device drive data
// R17: Write strobe low makes device take data
// R18: Acknowledge low marks data valid or taken
// R19: Ready low holds wait, high completes
// R20: Host holds full address, 8-bit data
// R21: Pins synchronised so each access acts once
module hbi_dev
   import hbi_pkg::*;
#(
   parameter int SCRATCH_DEPTH = 16,
   parameter int RESET_CNT = RESET_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   hbi_if.dev bus,
   input wire logic [7:0] irq_src,
   output logic [7:0] global_config,
   output logic core_reset_busy
);
   localparam int IDX_W = $clog2(SCRATCH_DEPTH);
   localparam int RST_W = 8;
   localparam int SW = 27;
   localparam logic [SW-1:0] SYNC_RST = {1'b0, 3'b000, 4'b1110, 19'h0};
   if (SCRATCH_DEPTH < 2 || SCRATCH_DEPTH > 16 || (1 << IDX_W) != SCRATCH_DEPTH) begin : g_chk_d
      $error("SCRATCH_DEPTH must be a power of two from 2 to 16");
   end
   if (RESET_CNT < 1 || RESET_CNT > RESET_CYCLES || RESET_CNT > 255) begin : g_chk_r
      $error("RESET_CNT must be 1 to the reset limit");
   end
   typedef enum logic [1:0] {
      P_IDLE = 2'b00,
      P_WAIT = 2'b01,
      P_DONE = 2'b10
   } hbi_pst_t;

   //------------------------------------------------------------------
   // Pin synchroniser
   //------------------------------------------------------------------
   logic [SW-1:0] sync1_r;
   logic [SW-1:0] sync2_r;
   always_ff @(posedge pclk or negedge presetn) begin // R21
      if (!presetn) begin
         sync1_r <= SYNC_RST;
         sync2_r <= SYNC_RST;
      end else begin
         sync1_r <= {bus.rst_pin_n, bus.par_sel, bus.bus_family_select,
            bus.bus_multiplex_select, bus.cs_n, bus.strb_pin, bus.dirwr_pin,
            bus.addr_capture_strobe, bus.addr, bus.d_bus};
         sync2_r <= sync1_r;
      end
   end
   logic s_rstn, s_par, s_fam, s_mux, s_cs_n, s_strb, s_dirwr, s_ale;
   logic [10:0] s_addr;
   logic [7:0] s_d;
   assign {s_rstn, s_par, s_fam, s_mux, s_cs_n, s_strb, s_dirwr, s_ale, s_addr, s_d} = sync2_r;

   //------------------------------------------------------------------
   // State
   //------------------------------------------------------------------
   hbi_pst_t state_r, state_nxt;
   logic [RST_W-1:0] rst_cnt_r, rst_cnt_nxt;
   logic busy_r, busy_nxt;
   logic [7:0] cfg_r, cfg_nxt, status_r, status_nxt, mask_r, mask_nxt;
   logic [10:0] mux_addr_r, mux_addr_nxt;
   logic [19:0] ser_in_r, ser_in_nxt;
   logic [4:0] ser_cnt_r, ser_cnt_nxt;
   logic ser_rd_r, ser_rd_nxt;
   logic [7:0] sh_out_r, sh_out_nxt, d_out_r, d_out_nxt;
   logic d_oe_r, d_oe_nxt, resp_r, resp_nxt, irq_r, irq_nxt, irq_oe_r, irq_oe_nxt;
   logic strb_q_r, ale_q_r;
   logic wr_go;
   logic [10:0] wr_addr, eff_addr;
   logic [7:0] wr_data;
   logic act, is_read, pend;
   logic [7:0] mem [SCRATCH_DEPTH];
   function automatic logic hit_scratch(input logic [10:0] a);
      return a >= ADR_SCRATCH_BASE && a < ADR_SCRATCH_BASE + 11'(SCRATCH_DEPTH);
   endfunction
   function automatic logic [7:0] read_reg(input logic [10:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a == ADR_GLOBAL_CONFIG) v = cfg_r;
      else if (a == ADR_IRQ_STATUS) v = status_r;
      else if (a == ADR_IRQ_MASK) v = mask_r;
      else if (hit_scratch(a)) v = mem[IDX_W'(a - ADR_SCRATCH_BASE)];
      return v;
   endfunction

   //------------------------------------------------------------------
   // Next-state logic
   //------------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      cfg_nxt = cfg_r;
      mask_nxt = mask_r;
      mux_addr_nxt = mux_addr_r;
      ser_in_nxt = ser_in_r;
      ser_cnt_nxt = ser_cnt_r;
      ser_rd_nxt = ser_rd_r;
      sh_out_nxt = sh_out_r;
      d_out_nxt = d_out_r;
      d_oe_nxt = d_oe_r;
      resp_nxt = resp_r;
      wr_go = 1'b0;
      wr_addr = 11'h000;
      wr_data = 8'h00;
      rst_cnt_nxt = !s_rstn ? RST_W'(RESET_CNT) : rst_cnt_r - RST_W'(rst_cnt_r != '0); // R1
      busy_nxt = !s_rstn || rst_cnt_r != '0; // R1
      act = s_fam ? (!s_strb || !s_dirwr) : !s_strb; // R7
      is_read = s_fam ? !s_strb : s_dirwr; // R14 R16 R17
      eff_addr = s_mux ? mux_addr_r : s_addr; // R8
      if (!s_par) begin // R6
         d_oe_nxt = 1'b0;
         state_nxt = P_IDLE;
         if (s_cs_n) begin // R4
            ser_cnt_nxt = 5'd0;
         end else if (s_strb && !strb_q_r && ser_cnt_r < 5'(SER_FRAME_BITS)) begin // R12
            ser_in_nxt = {ser_in_r[18:0], s_dirwr};
            ser_cnt_nxt = ser_cnt_r + 5'd1;
            if (ser_cnt_r == 5'(SER_HDR_BITS - 1)) begin
               ser_rd_nxt = ser_in_nxt[SER_HDR_BITS-1];
               sh_out_nxt = read_reg(ser_in_nxt[10:0]);
            end
            if (ser_cnt_r == 5'(SER_FRAME_BITS - 1) && !ser_in_nxt[19]) begin
               wr_go = 1'b1;
               wr_addr = ser_in_nxt[18:8];
               wr_data = ser_in_nxt[7:0];
            end
         end else if (!s_strb && strb_q_r && ser_rd_r && ser_cnt_r >= 5'(SER_HDR_BITS)
               && ser_cnt_r < 5'(SER_FRAME_BITS)) begin // R13
            resp_nxt = sh_out_r[7];
            sh_out_nxt = {sh_out_r[6:0], 1'b0};
         end
      end else begin
         if (!s_cs_n && s_mux && !s_ale && ale_q_r) begin // R9 R10
            mux_addr_nxt = {s_addr[10:8], s_d};
         end
         unique case (state_r)
            P_IDLE: begin
               resp_nxt = 1'b1;
               if (!s_cs_n && act) begin // R4
                  state_nxt = P_WAIT;
                  resp_nxt = !s_fam; // R19
               end
            end
            P_WAIT: begin
               if (s_cs_n) begin
                  state_nxt = P_IDLE;
                  resp_nxt = 1'b1;
               end else begin
                  state_nxt = P_DONE;
                  resp_nxt = s_fam; // R18 R19
                  if (is_read) begin // R14 R16
                     d_out_nxt = read_reg(eff_addr);
                     d_oe_nxt = 1'b1;
                  end else begin // R14 R17
                     wr_go = 1'b1;
                     wr_addr = eff_addr;
                     wr_data = s_d;
                  end
               end
            end
            P_DONE: begin
               if (s_cs_n || !act) begin
                  state_nxt = P_IDLE;
                  d_oe_nxt = 1'b0;
                  resp_nxt = 1'b1;
               end
            end
         endcase
      end
      if (busy_r) begin
         wr_go = 1'b0;
      end
      status_nxt = status_r;
      if (wr_go && wr_addr == ADR_GLOBAL_CONFIG) cfg_nxt = wr_data;
      if (wr_go && wr_addr == ADR_IRQ_MASK) mask_nxt = wr_data;
      if (wr_go && wr_addr == ADR_IRQ_STATUS) status_nxt = status_r & ~wr_data;
      status_nxt = status_nxt | irq_src;
      pend = |(status_r & ~mask_r); // R2
      irq_nxt = pend ? cfg_r[IRQ_LEVEL_BIT] : !cfg_r[IRQ_LEVEL_BIT]; // R3
      irq_oe_nxt = cfg_r[IRQ_OPEN_DRAIN_BIT] ? pend : 1'b1; // R3
      if (busy_r) begin // R1
         state_nxt = P_IDLE;
         cfg_nxt = GLOBAL_CONFIG_RST;
         status_nxt = 8'h00;
         mask_nxt = IRQ_MASK_RST;
         ser_cnt_nxt = 5'd0;
         ser_rd_nxt = 1'b0;
         d_oe_nxt = 1'b0;
         resp_nxt = 1'b1;
      end
   end

   //------------------------------------------------------------------
   // Registers
   //------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= P_IDLE;
         rst_cnt_r <= RST_W'(RESET_CNT);
         busy_r <= 1'b1;
         cfg_r <= GLOBAL_CONFIG_RST;
         status_r <= 8'h00;
         mask_r <= IRQ_MASK_RST;
         mux_addr_r <= 11'h000;
         ser_in_r <= 20'h00000;
         ser_cnt_r <= 5'd0;
         ser_rd_r <= 1'b0;
         sh_out_r <= 8'h00;
         d_out_r <= 8'h00;
         d_oe_r <= 1'b0;
         resp_r <= 1'b1;
         irq_r <= 1'b1;
         irq_oe_r <= 1'b1;
         strb_q_r <= 1'b1;
         ale_q_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         rst_cnt_r <= rst_cnt_nxt;
         busy_r <= busy_nxt;
         cfg_r <= cfg_nxt;
         status_r <= status_nxt;
         mask_r <= mask_nxt;
         mux_addr_r <= mux_addr_nxt;
         ser_in_r <= ser_in_nxt;
         ser_cnt_r <= ser_cnt_nxt;
         ser_rd_r <= ser_rd_nxt;
         sh_out_r <= sh_out_nxt;
         d_out_r <= d_out_nxt;
         d_oe_r <= d_oe_nxt;
         resp_r <= resp_nxt;
         irq_r <= irq_nxt;
         irq_oe_r <= irq_oe_nxt;
         strb_q_r <= s_strb;
         ale_q_r <= s_ale;
      end
   end
   // Scratch bytes, no reset
   always_ff @(posedge pclk) begin
      if (wr_go && hit_scratch(wr_addr)) begin
         mem[IDX_W'(wr_addr - ADR_SCRATCH_BASE)] <= wr_data;
      end
   end
   assign bus.d_dev = d_out_r;
   assign bus.d_dev_oe = d_oe_r;
   assign bus.resp_pin = resp_r;
   assign bus.irq_pin = irq_r;
   assign bus.irq_oe = irq_oe_r;
   assign global_config = cfg_r;
   assign core_reset_busy = busy_r;
endmodule
`default_nettype wire

// >>> src/hbi_host.sv
// Host controller end: APB registers driving the processor port pins
`timescale 1ns/1ps
`default_nettype none
module hbi_host
   import hbi_pkg::*;
#(
   parameter int PH = HOST_PHASE_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   hbi_if.host bus
);
   if (PH < 8 || PH > 15) begin : g_chk
      $error("PH must be 8 to 15");
   end

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_CS = 3'b001,
      H_ALE = 3'b010,
      H_STRB = 3'b011,
      H_WAIT = 3'b100,
      H_SER = 3'b101,
      H_REL = 3'b110,
      H_END = 3'b111
   } hbi_hst_t;

   //------------------------------------------------------------------
   // Pin synchroniser
   //------------------------------------------------------------------
   logic [9:0] sy1_r, sy2_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sy1_r <= 10'h3ff;
         sy2_r <= 10'h3ff;
      end else begin
         sy1_r <= {bus.d_bus, bus.resp_pin, bus.irq_line};
         sy2_r <= sy1_r;
      end
   end
   logic [7:0] s_d;
   logic s_resp, s_irq;
   assign {s_d, s_resp, s_irq} = sy2_r;

   //------------------------------------------------------------------
   // State
   //------------------------------------------------------------------
   hbi_hst_t st_r, st_nxt;
   logic [3:0] tmr_r, tmr_nxt, mode_r, mode_nxt;
   logic [4:0] bcnt_r, bcnt_nxt;
   logic [10:0] caddr_r, caddr_nxt, a_r, a_nxt;
   logic cwr_r, cwr_nxt, done_r, done_nxt, pready_r, pready_nxt;
   logic [7:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, rsh_r, rsh_nxt, d_r, d_nxt;
   logic [19:0] frame_r, frame_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic cs_r, cs_nxt, strb_r, strb_nxt, dw_r, dw_nxt, ale_r, ale_nxt, doe_r, doe_nxt;
   logic acc, start, t0, par, fam, mux;

   always_comb begin
      st_nxt = st_r;
      mode_nxt = mode_r;
      caddr_nxt = caddr_r;
      cwr_nxt = cwr_r;
      wdata_nxt = wdata_r;
      rdata_nxt = rdata_r;
      rsh_nxt = rsh_r;
      frame_nxt = frame_r;
      bcnt_nxt = bcnt_r;
      a_nxt = a_r;
      d_nxt = d_r;
      doe_nxt = doe_r;
      cs_nxt = cs_r;
      strb_nxt = strb_r;
      dw_nxt = dw_r;
      ale_nxt = ale_r;
      t0 = tmr_r == 4'd0;
      tmr_nxt = t0 ? 4'd0 : tmr_r - 4'd1;
      par = mode_r[MODE_PAR_BIT];
      fam = mode_r[MODE_FAM_BIT];
      mux = mode_r[MODE_MUX_BIT];
      acc = psel && penable && pready_r;
      start = acc && pwrite && paddr == APB_CMD && pwdata[CMD_START_BIT] && st_r == H_IDLE;
      done_nxt = done_r;
      if (acc && pwrite && paddr == APB_STATUS && pwdata[ST_DONE_BIT]) done_nxt = 1'b0;
      if (acc && pwrite && paddr == APB_WDATA) wdata_nxt = pwdata[7:0];
      if (acc && pwrite && paddr == APB_MODE && st_r == H_IDLE) mode_nxt = pwdata[3:0];
      pready_nxt = psel && !penable && !pready_r;
      prdata_nxt = prdata_r;
      if (psel && !penable) begin
         prdata_nxt = 32'h0;
         if (paddr == APB_CMD) prdata_nxt = {15'h0, cwr_r, 5'h0, caddr_r};
         if (paddr == APB_WDATA) prdata_nxt = {24'h0, wdata_r};
         if (paddr == APB_STATUS) prdata_nxt = {16'h0, rdata_r, 5'h0, s_irq, done_r,
            st_r != H_IDLE};
         if (paddr == APB_MODE) prdata_nxt = {28'h0, mode_r};
      end
      unique case (st_r)
         H_IDLE: begin
            ale_nxt = par; // R11
            strb_nxt = par;
            dw_nxt = par;
            if (start) begin
               caddr_nxt = pwdata[10:0];
               cwr_nxt = pwdata[CMD_WRITE_BIT];
               frame_nxt = {!pwdata[CMD_WRITE_BIT], pwdata[10:0], wdata_r};
               cs_nxt = 1'b0; // R5
               a_nxt = !par ? 11'h000 : (mux ? {pwdata[10:8], 8'h00} : pwdata[10:0]); // R20
               d_nxt = mux ? pwdata[7:0] : wdata_r;
               doe_nxt = par && (mux || pwdata[CMD_WRITE_BIT]);
               dw_nxt = par ? (!fam ? !pwdata[CMD_WRITE_BIT] : 1'b1) : dw_r; // R15
               tmr_nxt = 4'(PH);
               st_nxt = H_CS;
            end
         end
         H_CS: if (t0) begin
            tmr_nxt = 4'(PH);
            if (!par) begin
               dw_nxt = frame_r[19];
               bcnt_nxt = 5'd0;
               st_nxt = H_SER;
            end else if (mux) begin
               ale_nxt = 1'b0;
               st_nxt = H_ALE;
            end else begin
               st_nxt = H_STRB;
            end
         end
         H_ALE: if (t0) begin
            d_nxt = wdata_r;
            doe_nxt = cwr_r;
            tmr_nxt = 4'(PH);
            st_nxt = H_STRB;
         end
         H_STRB: if (t0) begin
            if (fam && cwr_r) dw_nxt = 1'b0; // R17
            else strb_nxt = 1'b0; // R16
            tmr_nxt = 4'(PH);
            st_nxt = H_WAIT;
         end
         H_WAIT: if (t0 && s_resp == fam) begin
            rdata_nxt = cwr_r ? rdata_r : s_d;
            strb_nxt = 1'b1;
            dw_nxt = 1'b1;
            tmr_nxt = 4'(PH);
            st_nxt = H_REL;
         end
         H_SER: if (t0) begin
            tmr_nxt = 4'(PH);
            if (!strb_r) begin // R12
               strb_nxt = 1'b1;
               if (bcnt_r >= 5'(SER_HDR_BITS)) rsh_nxt = {rsh_r[6:0], s_resp};
            end else begin
               strb_nxt = 1'b0;
               frame_nxt = {frame_r[18:0], 1'b0};
               dw_nxt = frame_nxt[19];
               bcnt_nxt = bcnt_r + 5'd1;
               if (bcnt_r == 5'(SER_FRAME_BITS - 1)) begin
                  rdata_nxt = cwr_r ? rdata_r : rsh_r;
                  st_nxt = H_REL;
               end
            end
         end
         H_REL: if (t0) begin
            cs_nxt = 1'b1;
            doe_nxt = 1'b0;
            tmr_nxt = 4'(PH);
            st_nxt = H_END;
         end
         H_END: if (t0) begin
            done_nxt = 1'b1;
            st_nxt = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= H_IDLE;
         tmr_r <= 4'd0;
         mode_r <= MODE_RST;
         bcnt_r <= 5'd0;
         caddr_r <= 11'h000;
         a_r <= 11'h000;
         cwr_r <= 1'b0;
         done_r <= 1'b0;
         pready_r <= 1'b0;
         wdata_r <= 8'h00;
         rdata_r <= 8'h00;
         rsh_r <= 8'h00;
         d_r <= 8'h00;
         frame_r <= 20'h00000;
         prdata_r <= 32'h0;
         cs_r <= 1'b1;
         strb_r <= 1'b1;
         dw_r <= 1'b1;
         ale_r <= 1'b1;
         doe_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         tmr_r <= tmr_nxt;
         mode_r <= mode_nxt;
         bcnt_r <= bcnt_nxt;
         caddr_r <= caddr_nxt;
         a_r <= a_nxt;
         cwr_r <= cwr_nxt;
         done_r <= done_nxt;
         pready_r <= pready_nxt;
         wdata_r <= wdata_nxt;
         rdata_r <= rdata_nxt;
         rsh_r <= rsh_nxt;
         d_r <= d_nxt;
         frame_r <= frame_nxt;
         prdata_r <= prdata_nxt;
         cs_r <= cs_nxt;
         strb_r <= strb_nxt;
         dw_r <= dw_nxt;
         ale_r <= ale_nxt;
         doe_r <= doe_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = 1'b0;
   assign bus.rst_pin_n = !mode_r[MODE_RST_BIT];
   assign bus.par_sel = mode_r[MODE_PAR_BIT];
   assign bus.bus_family_select = mode_r[MODE_FAM_BIT];
   assign bus.bus_multiplex_select = mode_r[MODE_MUX_BIT];
   assign bus.cs_n = cs_r;
   assign bus.strb_pin = strb_r;
   assign bus.dirwr_pin = dw_r;
   assign bus.addr_capture_strobe = ale_r;
   assign bus.addr = a_r;
   assign bus.d_host = d_r;
   assign bus.d_host_oe = doe_r;
endmodule
`default_nettype wire

// >>> verif/hbi_assertions.sv
// Pin-level checks on the link between host and device
`timescale 1ns/1ps
`default_nettype none
module hbi_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic par_sel,
   input wire logic bus_family_select,
   input wire logic cs_n,
   input wire logic strb_pin,
   input wire logic rst_pin_n,
   input wire logic resp_pin,
   input wire logic d_dev_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire f0 = par_sel && !bus_family_select;
   wire f1 = par_sel && bus_family_select;
   property p_idle; cs_n [*6] |-> !d_dev_oe; endproperty
   a_idle: assert property (p_idle) else $error("data driven while deselected");
   property p_ack_idle; (f0 && cs_n) [*6] |-> resp_pin; endproperty
   a_ack_idle: assert property (p_ack_idle) else $error("ack low while deselected");
   property p_ack_cause; f0 && $fell(resp_pin) |-> !cs_n && !strb_pin; endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without strobe");
   property p_ack_hold; f0 && !resp_pin && !strb_pin && !cs_n |=> !resp_pin; endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
   property p_rdy; f1 && !cs_n && !strb_pin && $fell(resp_pin) |=> resp_pin; endproperty
   a_rdy: assert property (p_rdy) else $error("wait state too long");
   property p_ser; !par_sel && !cs_n && $changed(resp_pin) |-> !strb_pin; endproperty
   a_ser: assert property (p_ser) else $error("serial out moved off the fall");
   property p_rst; $rose(rst_pin_n) |-> !d_dev_oe [*8]; endproperty
   a_rst: assert property (p_rst) else $error("bus driven in reset sequence");
   property p_par; d_dev_oe |-> par_sel; endproperty
   a_par: assert property (p_par) else $error("data driven in serial mode");
endmodule
`default_nettype wire

// >>> verif/test_host_processor_bus_interface.sv
// Bench joining host controller and device port over the pin bundle
`timescale 1ns/1ps
`default_nettype none
module test_host_processor_bus_interface
   import hbi_pkg::*;
();
   localparam int RC = 10;
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic [7:0] irq_src = '0;
   logic [7:0] global_config;
   logic core_reset_busy;
   logic [31:0] r;
   logic [7:0] rd;
   int bad_count = 0;
   int compares = 0;
   int i;
   // Mode, address, write data, expected read
   logic [30:0] rows [6] = '{{4'h1, 11'h7ff, 8'h33, 8'h00}, {4'h1, 11'h010, 8'ha5, 8'ha5},
      {4'h3, 11'h01f, 8'h5a, 8'h5a}, {4'h5, 11'h011, 8'hc3, 8'hc3},
      {4'h7, 11'h01e, 8'h3c, 8'h3c}, {4'h0, 11'h012, 8'h96, 8'h96}};
   hbi_if lnk ();
   hbi_dev #(.RESET_CNT(RC)) i_hbi_dev (.pclk(pclk), .presetn(presetn), .bus(lnk),
      .irq_src(irq_src), .global_config(global_config), .core_reset_busy(core_reset_busy));
   hbi_host i_hbi_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(), .bus(lnk));
   hbi_assertions i_hbi_assertions (.pclk(pclk), .presetn(presetn), .par_sel(lnk.par_sel),
      .bus_family_select(lnk.bus_family_select), .cs_n(lnk.cs_n), .strb_pin(lnk.strb_pin),
      .rst_pin_n(lnk.rst_pin_n), .resp_pin(lnk.resp_pin), .d_dev_oe(lnk.d_dev_oe));
   always #5 pclk = ~pclk;
   task automatic end_of_test();
      $display("compares %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic to(input logic hit);
      if (hit) begin
         bad_count++;
         end_of_test();
      end
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         $display("unexpected at %0t: got %h, expected %h", $time, g, e);
         bad_count++;
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      to(n >= 20);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic acc(input logic w, input logic [10:0] a, input logic [7:0] d);
      int n;
      apb(1'b1, APB_WDATA, {24'h0, d});
      apb(1'b1, APB_CMD, 32'h8000_0000 | (32'(w) << CMD_WRITE_BIT) | 32'(a));
      n = 0;
      do begin
         apb(1'b0, APB_STATUS, 32'h0);
         n++;
      end while (r[ST_DONE_BIT] !== 1'b1 && n < 300);
      to(n >= 300);
      rd = r[15:8];
      apb(1'b1, APB_STATUS, 32'h2);
   endtask
   task automatic wait_idle();
      int n;
      for (n = 0; n < RC + 8 && core_reset_busy !== 1'b0; n++) begin
         @(negedge pclk);
      end
      to(n >= RC + 8);
   endtask
   task automatic irq_chk(input logic [10:0] a, input logic [7:0] d, input logic e);
      acc(1'b1, a, d);
      apb(1'b0, APB_STATUS, 32'h0);
      chk(32'(r[ST_IRQ_BIT]), 32'(e));
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      wait_idle();
      chk(32'(global_config), 32'(GLOBAL_CONFIG_RST));
      for (i = 0; i < 6; i++) begin
         apb(1'b1, APB_MODE, {28'h0, rows[i][30:27]});
         acc(1'b1, rows[i][26:16], rows[i][15:8]);
         acc(1'b0, rows[i][26:16], 8'h00);
         chk({24'h0, rd}, {24'h0, rows[i][7:0]});
         $display("row %0d done", i);
      end
      @(posedge pclk);
      irq_src <= 8'h01;
      @(posedge pclk);
      irq_src <= 8'h00;
      // Active low push-pull, then high, then open drain driven low, then released and pulled high
      irq_chk(ADR_IRQ_MASK, 8'hfe, 1'b0);
      irq_chk(ADR_GLOBAL_CONFIG, 8'h04, 1'b1);
      irq_chk(ADR_GLOBAL_CONFIG, 8'h08, 1'b0);
      irq_chk(ADR_IRQ_MASK, 8'hff, 1'b1);
      $display("request test done");
      acc(1'b1, ADR_IRQ_MASK, 8'h00);
      apb(1'b1, APB_MODE, 32'h8);
      apb(1'b1, APB_MODE, 32'h0);
      @(negedge pclk);
      chk(32'(core_reset_busy), 32'h1);
      wait_idle();
      chk(32'(global_config), 32'(GLOBAL_CONFIG_RST));
      acc(1'b0, ADR_IRQ_MASK, 8'h00);
      chk({24'h0, rd}, {24'h0, IRQ_MASK_RST});
      $display("reset pin test done");
      end_of_test();
   end
endmodule
`default_nettype wire
